/* hw/tncr_cfg_byte.sv */
/*
  tncr_cfg_byte: one byte-wide configuration register with two reset sources.
  Assumes: write, watchdog and register-reset strobes are one-cycle pulses on
  core_clk; reserved bits are masked off on write.
*/
`timescale 1ns/1ps
`default_nettype none

module tncr_cfg_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WR_MASK   = 8'hff,
  parameter logic [7:0] WD_MASK   = 8'hff
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       wd_expire,
  input  wire logic       soft_reset,
  output var  logic [7:0] q
);

  // ==========================================================================
  // storage: register reset beats watchdog beats write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= RESET_VAL;
    end else if (soft_reset) begin
      q <= RESET_VAL;
    end else if (wd_expire) begin
      q <= (q & ~WD_MASK) | (RESET_VAL & WD_MASK);
    end else if (wr_en) begin
      q <= wr_data & WR_MASK;
    end
  end

endmodule : tncr_cfg_byte

`default_nettype wire

/* hw/tncr_pkg.sv */
/*
  tncr_pkg: shared constants, register layouts and field decoders for the
  thermal and thermistor configuration register bank.
  Assumes: register offsets are byte addresses on the device register port.
*/
package tncr_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] TNCR_OFS_THERMAL = 8'h16; // thermal_limit_config
  localparam logic [7:0] TNCR_OFS_ADJUST  = 8'h17; // battery_temp_charge_adjust
  localparam logic [7:0] TNCR_OFS_WINDOW  = 8'h18; // battery_temp_window_config

  // ==========================================================================
  // reset values
  localparam logic [7:0] TNCR_RST_THERMAL = 8'hc0;
  localparam logic [7:0] TNCR_RST_ADJUST  = 8'h7a;
  localparam logic [7:0] TNCR_RST_WINDOW  = 8'h54;

  // writable bits; reserved bits stay zero
  localparam logic [7:0] TNCR_WMASK_THERMAL = 8'hfe;
  localparam logic [7:0] TNCR_WMASK_ADJUST  = 8'hfe;
  localparam logic [7:0] TNCR_WMASK_WINDOW  = 8'hff;

  // bits that watchdog expiry returns to default
  localparam logic [7:0] TNCR_WDMASK_THERMAL = 8'hf0;
  localparam logic [7:0] TNCR_WDMASK_ADJUST  = 8'hfe;
  localparam logic [7:0] TNCR_WDMASK_WINDOW  = 8'hff;

  // unmapped read answer
  localparam logic [7:0] TNCR_RD_UNMAPPED = 8'h00;

  // thermistor status width and normal code
  localparam int unsigned TNCR_TH_BITS   = 4;
  localparam logic [3:0]  TNCR_TH_NORMAL = 4'h0;

  // ==========================================================================
  // field layouts, msb first
  typedef struct packed {
    logic [1:0] die_thermal_reg_threshold;      // bits 7-6
    logic [1:0] die_thermal_shutdown_threshold; // bits 5-4
    logic       input_rail_pulldown_enable;     // bit 3
    logic       sense_node_a_pulldown_enable;   // bit 2
    logic       sense_node_b_pulldown_enable;   // bit 1
    logic       rsvd;                           // bit 0
  } tncr_thermal_s;

  typedef struct packed {
    logic [2:0] warm_range_voltage_adjust; // bits 7-5
    logic [1:0] warm_range_current_adjust; // bits 4-3
    logic [1:0] cool_range_current_adjust; // bits 2-1
    logic       rsvd;                      // bit 0
  } tncr_adjust_s;

  typedef struct packed {
    logic [1:0] cool_comparator_threshold; // bits 7-6
    logic [1:0] warm_comparator_threshold; // bits 5-4
    logic [1:0] reverse_supply_hot_limit;  // bits 3-2
    logic       reverse_supply_cold_limit; // bit 1
    logic       thermistor_override;       // bit 0
  } tncr_window_s;

  // decoded charge-side settings
  typedef struct packed {
    logic       warm_suspend;     // warm range charging suspended
    logic [9:0] warm_vdrop_mv;    // drop of charge_voltage_target
    logic       warm_i_suspend;
    logic [6:0] warm_i_pct;       // percent of charge_current_target
    logic       cool_i_suspend;
    logic [6:0] cool_i_pct;
  } tncr_charge_s;

  // decoded thermistor window settings
  typedef struct packed {
    logic [9:0] cool_thr_permille; // of internal_regulator_rail
    logic [9:0] warm_thr_permille;
    logic       hot_limit_off;
    logic [7:0] hot_limit_degc;
    logic [7:0] cold_limit_below0; // degrees below zero
  } tncr_window_dec_s;

  // ==========================================================================
  // field decoders
  function automatic logic [7:0] tncr_reg_degc(input logic [1:0] code);
    case (code)
      2'h0:    tncr_reg_degc = 8'd60;
      2'h1:    tncr_reg_degc = 8'd80;
      2'h2:    tncr_reg_degc = 8'd100;
      default: tncr_reg_degc = 8'd120;
    endcase
  endfunction : tncr_reg_degc

  function automatic logic [7:0] tncr_shut_degc(input logic [1:0] code);
    case (code)
      2'h0:    tncr_shut_degc = 8'd150;
      2'h1:    tncr_shut_degc = 8'd130;
      2'h2:    tncr_shut_degc = 8'd120;
      default: tncr_shut_degc = 8'd85;
    endcase
  endfunction : tncr_shut_degc

  function automatic logic [9:0] tncr_vdrop_mv(input logic [2:0] code);
    case (code)
      3'h1:         tncr_vdrop_mv = 10'd800;
      3'h2:         tncr_vdrop_mv = 10'd600;
      3'h3, 3'h4:   tncr_vdrop_mv = 10'd400;
      3'h5:         tncr_vdrop_mv = 10'd200;
      3'h6:         tncr_vdrop_mv = 10'd100;
      default:      tncr_vdrop_mv = 10'd0;
    endcase
  endfunction : tncr_vdrop_mv

  // shared by warm and cool current fields
  function automatic logic [6:0] tncr_i_pct(input logic [1:0] code);
    case (code)
      2'h0:    tncr_i_pct = 7'd0;
      2'h1:    tncr_i_pct = 7'd20;
      2'h2:    tncr_i_pct = 7'd40;
      default: tncr_i_pct = 7'd100;
    endcase
  endfunction : tncr_i_pct

  function automatic logic [9:0] tncr_cool_pm(input logic [1:0] code);
    case (code)
      2'h0:    tncr_cool_pm = 10'd711;
      2'h1:    tncr_cool_pm = 10'd684;
      2'h2:    tncr_cool_pm = 10'd655;
      default: tncr_cool_pm = 10'd624;
    endcase
  endfunction : tncr_cool_pm

  function automatic logic [9:0] tncr_warm_pm(input logic [1:0] code);
    case (code)
      2'h0:    tncr_warm_pm = 10'd484;
      2'h1:    tncr_warm_pm = 10'd448;
      2'h2:    tncr_warm_pm = 10'd412;
      default: tncr_warm_pm = 10'd377;
    endcase
  endfunction : tncr_warm_pm

  function automatic logic [7:0] tncr_hot_degc(input logic [1:0] code);
    case (code)
      2'h0:    tncr_hot_degc = 8'd55;
      2'h1:    tncr_hot_degc = 8'd60;
      2'h2:    tncr_hot_degc = 8'd65;
      default: tncr_hot_degc = 8'd0;
    endcase
  endfunction : tncr_hot_degc

endpackage : tncr_pkg

/* hw/tncr_status_sync.sv */
/*
  tncr_status_sync: brings comparator status levels onto core_clk.
  Assumes: inputs are asynchronous levels; a change is accepted once the
  second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none

module tncr_status_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  genvar gi;

  // ==========================================================================
  // per-bit three-stage chain with agreement filter
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;

      // chain; s1 only feeds s2
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
        end else begin
          s1_reg <= async_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end

      // accept only when stages two and three agree
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          sync_out[gi] <= 1'b0;
        end else if (s2_reg == s3_reg) begin
          sync_out[gi] <= s3_reg;
        end
      end
    end
  endgenerate

endmodule : tncr_status_sync

`default_nettype wire

/* hw/tncr_top.sv */
/*
  tncr_top: thermal limit and battery-thermistor configuration register bank.
  Holds three byte registers, decodes their fields for the analog loops and
  applies the thermistor override to the good flag and status bits.
  Assumes: a serial-bus decoder drives the byte register port on core_clk;
  watchdog expiry and register reset arrive as one-cycle pulses on core_clk;
  thermistor status and good levels come from asynchronous comparators.

*/
`timescale 1ns/1ps
`default_nettype none

module tncr_top #(
  parameter int unsigned TH_BITS = tncr_pkg::TNCR_TH_BITS
) (
  input  wire logic                              core_clk,
  input  wire logic                              rstn,
  // byte register port
  input  wire logic [7:0]                        reg_addr,
  input  wire logic                              reg_wr,
  input  wire logic [7:0]                        reg_wdata,
  input  wire logic                              reg_rd,
  output var  logic [7:0]                        reg_rdata,
  output var  logic                              reg_rvalid,
  // reset sources
  input  wire logic                              wd_expire,
  input  wire logic                              reg_reset,
  // thermistor comparator side
  input  wire logic [TH_BITS-1:0]                th_status_raw,
  input  wire logic                              th_good_raw,
  output var  logic [TH_BITS-1:0]                th_status,
  output var  logic                              th_good,
  // die thermal settings
  output var  logic [1:0]                        die_thermal_reg_threshold,
  output var  logic [1:0]                        die_thermal_shutdown_threshold,
  output var  logic [7:0]                        die_reg_degc,
  output var  logic [7:0]                        die_shut_degc,
  // pull-down load switches
  output var  logic                              input_rail_pulldown_enable,
  output var  logic                              sense_node_a_pulldown_enable,
  output var  logic                              sense_node_b_pulldown_enable,
  // raw and decoded battery-temperature settings
  output var  tncr_pkg::tncr_adjust_s            adjust_cfg,
  output var  tncr_pkg::tncr_window_s            window_cfg,
  output var  tncr_pkg::tncr_charge_s            charge_dec,
  output var  tncr_pkg::tncr_window_dec_s        window_dec
);

  // ==========================================================================
  // address decode and register storage
  logic                   sel_thermal;
  logic                   sel_adjust;
  logic                   sel_window;
  logic [7:0]             thermal_q;
  logic [7:0]             adjust_q;
  logic [7:0]             window_q;
  tncr_pkg::tncr_thermal_s thermal_v;
  tncr_pkg::tncr_adjust_s  adjust_v;
  tncr_pkg::tncr_window_s  window_v;
  logic [TH_BITS-1:0]     th_status_sync;
  logic [TH_BITS-1:0]     th_normal;
  logic                   th_good_sync;

  // offset compare per register
  assign sel_thermal = (reg_addr == tncr_pkg::TNCR_OFS_THERMAL);
  assign sel_adjust  = (reg_addr == tncr_pkg::TNCR_OFS_ADJUST);
  assign sel_window  = (reg_addr == tncr_pkg::TNCR_OFS_WINDOW);

  // typed views of the stored bytes
  assign thermal_v = tncr_pkg::tncr_thermal_s'(thermal_q);
  assign adjust_v  = tncr_pkg::tncr_adjust_s'(adjust_q);
  assign window_v  = tncr_pkg::tncr_window_s'(window_q);
  assign th_normal = TH_BITS'(tncr_pkg::TNCR_TH_NORMAL);

  // thermal limits and pull-downs; pull-downs skip watchdog
  tncr_cfg_byte #(
    .RESET_VAL (tncr_pkg::TNCR_RST_THERMAL),
    .WR_MASK   (tncr_pkg::TNCR_WMASK_THERMAL),
    .WD_MASK   (tncr_pkg::TNCR_WDMASK_THERMAL)
  ) u_thermal (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .wr_en      (reg_wr && sel_thermal),
    .wr_data    (reg_wdata),
    .wd_expire  (wd_expire),
    .soft_reset (reg_reset),
    .q          (thermal_q)
  );

  // warm and cool charge adjustments
  tncr_cfg_byte #(
    .RESET_VAL (tncr_pkg::TNCR_RST_ADJUST),
    .WR_MASK   (tncr_pkg::TNCR_WMASK_ADJUST),
    .WD_MASK   (tncr_pkg::TNCR_WDMASK_ADJUST)
  ) u_adjust (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .wr_en      (reg_wr && sel_adjust),
    .wr_data    (reg_wdata),
    .wd_expire  (wd_expire),
    .soft_reset (reg_reset),
    .q          (adjust_q)
  );

  // comparator windows, reverse-supply limits, override
  tncr_cfg_byte #(
    .RESET_VAL (tncr_pkg::TNCR_RST_WINDOW),
    .WR_MASK   (tncr_pkg::TNCR_WMASK_WINDOW),
    .WD_MASK   (tncr_pkg::TNCR_WDMASK_WINDOW)
  ) u_window (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .wr_en      (reg_wr && sel_window),
    .wr_data    (reg_wdata),
    .wd_expire  (wd_expire),
    .soft_reset (reg_reset),
    .q          (window_q)
  );

  // comparator status and good flag onto core_clk
  tncr_status_sync #(
    .WIDTH (TH_BITS + 1)
  ) u_th_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({th_good_raw, th_status_raw}),
    .sync_out ({th_good_sync, th_status_sync})
  );

  // ==========================================================================
  // register read port: answer one cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata  <= tncr_pkg::TNCR_RD_UNMAPPED;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (sel_thermal) begin
          reg_rdata <= thermal_q;   // reserved bit 0 stored as zero
        end else if (sel_adjust) begin
          reg_rdata <= adjust_q;
        end else if (sel_window) begin
          reg_rdata <= window_q;
        end else begin
          reg_rdata <= tncr_pkg::TNCR_RD_UNMAPPED;
        end
      end
    end
  end

  // ==========================================================================
  // die thermal thresholds and their decoded temperatures
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      die_thermal_reg_threshold      <= 2'h3;
      die_thermal_shutdown_threshold <= 2'h0;
      die_reg_degc                   <= 8'd120;
      die_shut_degc                  <= 8'd150;
    end else begin
      die_thermal_reg_threshold      <= thermal_v.die_thermal_reg_threshold;
      die_thermal_shutdown_threshold <= thermal_v.die_thermal_shutdown_threshold;
      die_reg_degc  <= tncr_pkg::tncr_reg_degc(thermal_v.die_thermal_reg_threshold);
      die_shut_degc <= tncr_pkg::tncr_shut_degc(thermal_v.die_thermal_shutdown_threshold);
    end
  end

  // ==========================================================================
  // pull-down load switches
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      input_rail_pulldown_enable   <= 1'b0;
      sense_node_a_pulldown_enable <= 1'b0;
      sense_node_b_pulldown_enable <= 1'b0;
    end else begin
      input_rail_pulldown_enable   <= thermal_v.input_rail_pulldown_enable;
      sense_node_a_pulldown_enable <= thermal_v.sense_node_a_pulldown_enable;
      sense_node_b_pulldown_enable <= thermal_v.sense_node_b_pulldown_enable;
    end
  end

  // ==========================================================================
  // raw field copies for the charge and window logic
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      adjust_cfg <= tncr_pkg::tncr_adjust_s'(tncr_pkg::TNCR_RST_ADJUST);
      window_cfg <= tncr_pkg::tncr_window_s'(tncr_pkg::TNCR_RST_WINDOW);
    end else begin
      adjust_cfg <= adjust_v;
      window_cfg <= window_v;
    end
  end

  // ==========================================================================
  // warm and cool range charge adjustments
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      charge_dec.warm_suspend   <= 1'b0;
      charge_dec.warm_vdrop_mv  <= 10'd400;
      charge_dec.warm_i_suspend <= 1'b0;
      charge_dec.warm_i_pct     <= 7'd100;
      charge_dec.cool_i_suspend <= 1'b0;
      charge_dec.cool_i_pct     <= 7'd20;
    end else begin
      charge_dec.warm_suspend   <= (adjust_v.warm_range_voltage_adjust == 3'h0);
      charge_dec.warm_vdrop_mv  <=
        tncr_pkg::tncr_vdrop_mv(adjust_v.warm_range_voltage_adjust);
      charge_dec.warm_i_suspend <= (adjust_v.warm_range_current_adjust == 2'h0);
      charge_dec.warm_i_pct     <=
        tncr_pkg::tncr_i_pct(adjust_v.warm_range_current_adjust);
      charge_dec.cool_i_suspend <= (adjust_v.cool_range_current_adjust == 2'h0);
      charge_dec.cool_i_pct     <=
        tncr_pkg::tncr_i_pct(adjust_v.cool_range_current_adjust);
    end
  end

  // ==========================================================================
  // comparator thresholds and reverse-supply limits
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      window_dec.cool_thr_permille <= 10'd684;
      window_dec.warm_thr_permille <= 10'd448;
      window_dec.hot_limit_off     <= 1'b0;
      window_dec.hot_limit_degc    <= 8'd60;
      window_dec.cold_limit_below0 <= 8'd10;
    end else begin
      window_dec.cool_thr_permille <=
        tncr_pkg::tncr_cool_pm(window_v.cool_comparator_threshold);
      window_dec.warm_thr_permille <=
        tncr_pkg::tncr_warm_pm(window_v.warm_comparator_threshold);
      window_dec.hot_limit_off     <= (window_v.reverse_supply_hot_limit == 2'h3);
      window_dec.hot_limit_degc    <=
        tncr_pkg::tncr_hot_degc(window_v.reverse_supply_hot_limit);
      window_dec.cold_limit_below0 <=
        window_v.reverse_supply_cold_limit ? 8'd20 : 8'd10;
    end
  end

  // ==========================================================================
  // thermistor override: good flag forced, status forced normal
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      th_good   <= 1'b0;
      th_status <= '0;
    end else begin
      th_good   <= window_v.thermistor_override | th_good_sync;
      th_status <= window_v.thermistor_override ? th_normal : th_status_sync;
    end
  end

endmodule : tncr_top

`default_nettype wire

/* sim/tb_thermal_ntc_config_regs.sv */
/* tb_thermal_ntc_config_regs: self-checking bench for tncr_top.
   Assumes: host model drives the byte port, checker is bound in. */
`timescale 1ns/1ps
`default_nettype none
module tb_thermal_ntc_config_regs;
  // ==================================================================
  logic                       core_clk = 1'b0;
  logic                       rstn;
  logic                       wd_expire;
  logic                       reg_reset;
  logic                       reg_wr;
  logic                       reg_rd;
  logic                       reg_rvalid;
  logic                       th_good_raw;
  logic                       th_good;
  logic [3:0]                 th_status_raw;
  logic [3:0]                 th_status;
  logic [1:0]                 st;
  logic [7:0]                 reg_addr;
  logic [7:0]                 reg_wdata;
  logic [7:0]                 reg_rdata;
  logic [7:0]                 die_reg_degc;
  logic [7:0]                 die_shut_degc;
  logic [7:0]                 a;
  logic [7:0]                 d;
  logic [2:0]                 v;
  wire  [2:0]                 pd;
  tncr_pkg::tncr_charge_s     charge_dec;
  tncr_pkg::tncr_window_dec_s window_dec;
  logic [7:0]                 exp_q[$];
  int                         n_mismatch = 0;
  int                         num_checks = 0;
  int vd[8] = '{0, 800, 600, 400, 400, 200, 100, 0};
  int ip[4] = '{0, 20, 40, 100};
  int sd[4] = '{150, 130, 120, 85};
  int cp[4] = '{711, 684, 655, 624};
  int wp[4] = '{484, 448, 412, 377};
  tncr_top dut_u (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .wd_expire(wd_expire), .reg_reset(reg_reset), .th_status_raw(th_status_raw),
    .th_good_raw(th_good_raw), .th_status(th_status), .th_good(th_good),
    .die_thermal_reg_threshold(), .die_thermal_shutdown_threshold(st),
    .die_reg_degc(die_reg_degc), .die_shut_degc(die_shut_degc),
    .input_rail_pulldown_enable(pd[2]), .sense_node_a_pulldown_enable(pd[1]),
    .sense_node_b_pulldown_enable(pd[0]), .adjust_cfg(), .window_cfg(),
    .charge_dec(charge_dec), .window_dec(window_dec));
  tncr_host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  task automatic check(input logic [15:0] got, input int exp);
    num_checks++;
    if (got !== 16'(exp)) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, 16'(exp));
    end
  endtask : check
  task automatic rd(input logic [7:0] ra, input logic [7:0] re);
    exp_q.push_back(re);
    host_u.xfer(1'b0, ra, 8'h00);
  endtask : rd
  task automatic pulse(input logic wd);
    @(negedge core_clk);
    wd_expire = wd;
    reg_reset = !wd;
    @(negedge core_clk);
    wd_expire = 1'b0;
    reg_reset = 1'b0;
  endtask : pulse
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // read answers against the oldest note
  always @(negedge core_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[ERR] %0t unexpected read", $time);
      end else begin
        check(reg_rdata, exp_q.pop_front());
      end
    end
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    wd_expire = 1'b0;
    reg_reset = 1'b0;
    th_status_raw = 4'ha;
    th_good_raw = 1'b0;
    void'($urandom(64032));
    repeat (20) @(negedge core_clk);
    rstn = 1'b1;
    rd(8'h16, 8'hc0);
    rd(8'h17, 8'h7a);
    rd(8'h18, 8'h54);
    rd(8'h19, 8'h00);
    check(pd, 0);
    check(th_status, 4'ha);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      a = 8'h16 + 8'(i % 3);
      d = 8'($urandom());
      host_u.xfer(1'b1, a, d);
      rd(a, (i % 3 == 2) ? d : d & 8'hfe);
    end
    for (int c = 0; c < 8; c++) begin
      v = 3'(c);
      host_u.xfer(1'b1, 8'h16, {v[1:0], v[1:0], 4'h0});
      host_u.xfer(1'b1, 8'h17, {v, v[1:0], v[1:0], 1'b0});
      host_u.xfer(1'b1, 8'h18, {v[1:0], v[1:0], v[1:0], v[0], 1'b0});
      repeat (3) @(negedge core_clk);
      check(die_reg_degc, 60 + 20 * v[1:0]);
      check(die_shut_degc, sd[v[1:0]]);
      check(st, v[1:0]);
      check(charge_dec.warm_vdrop_mv, vd[c]);
      check(charge_dec.warm_suspend, c == 0);
      check(charge_dec.warm_i_pct, ip[v[1:0]]);
      check(charge_dec.warm_i_suspend, v[1:0] == 0);
      check(charge_dec.cool_i_pct, ip[v[1:0]]);
      check(charge_dec.cool_i_suspend, v[1:0] == 0);
      check(window_dec.cool_thr_permille, cp[v[1:0]]);
      check(window_dec.warm_thr_permille, wp[v[1:0]]);
      check(window_dec.hot_limit_off, v[1:0] == 2'h3);
      check(window_dec.hot_limit_degc, v[1:0] > 2 ? 0 : 55 + 5 * v[1:0]);
      check(window_dec.cold_limit_below0, v[0] ? 20 : 10);
    end
    $display("test decode done");
    host_u.xfer(1'b1, 8'h16, 8'hfe);
    pulse(1'b1);
    rd(8'h16, 8'hce);
    check(pd, 7);
    host_u.xfer(1'b1, 8'h17, 8'h00);
    host_u.xfer(1'b1, 8'h18, 8'hfe);
    pulse(1'b1);
    rd(8'h17, 8'h7a);
    rd(8'h18, 8'h54);
    pulse(1'b0);
    rd(8'h16, 8'hc0);
    $display("test resets done");
    host_u.xfer(1'b1, 8'h18, 8'h55);
    th_status_raw = 4'($urandom()) | 4'h1;
    repeat (8) @(negedge core_clk);
    check(th_status, 0);
    check(th_good, 1);
    host_u.xfer(1'b1, 8'h18, 8'h54);
    repeat (8) @(negedge core_clk);
    check(th_status, th_status_raw);
    check(th_good, 0);
    check(exp_q.size(), 0);
    $display("test override done");
    stop_test();
  end
endmodule : tb_thermal_ntc_config_regs
`default_nettype wire

/* sim/tncr_host_model.sv */
/* tncr_host_model: host side of the byte register port.
   Assumes: requests launched at the falling edge of core_clk. */
`timescale 1ns/1ps
`default_nettype none
module tncr_host_model (
  input  wire logic       core_clk,
  output var  logic [7:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_rd
);
  // ==================================================================
  // idle port at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one strobe cycle, then released lines show inverted values
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = wr ? d : ~d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask : xfer
endmodule : tncr_host_model
`default_nettype wire

/* sim/tncr_top_properties.sv */
/* tncr_top_chk: port assertions on tncr_top.
   Assumes: bound onto tncr_top, one clock domain core_clk. */
`timescale 1ns/1ps
`default_nettype none
module tncr_top_chk #(
  parameter int unsigned TH_BITS = 4
) (
  input wire logic                       core_clk,
  input wire logic                       rstn,
  input wire logic [7:0]                 reg_addr,
  input wire logic [7:0]                 reg_rdata,
  input wire logic                       reg_rvalid,
  input wire logic                       wd_expire,
  input wire logic                       reg_reset,
  input wire logic [TH_BITS-1:0]         th_status,
  input wire logic                       th_good,
  input wire logic [1:0]                 die_thermal_reg_threshold,
  input wire logic [7:0]                 die_reg_degc,
  input wire logic                       input_rail_pulldown_enable,
  input wire logic                       sense_node_a_pulldown_enable,
  input wire logic                       sense_node_b_pulldown_enable,
  input wire tncr_pkg::tncr_adjust_s     adjust_cfg,
  input wire tncr_pkg::tncr_window_s     window_cfg,
  input wire tncr_pkg::tncr_window_dec_s window_dec
);
  // ==================================================================
  // pull-down enables as one vector
  wire [2:0] pd = {input_rail_pulldown_enable, sense_node_a_pulldown_enable,
                   sense_node_b_pulldown_enable};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  reg_decode_a: assert property (
    die_reg_degc == 8'd60 + 8'd20 * die_thermal_reg_threshold) else $error("bad degrees");
  pd_keep_a: assert property (
    wd_expire && !reg_reset |=> ##1 $stable(pd)) else $error("pull-down lost on watchdog");
  pd_clear_a: assert property (
    reg_reset |=> ##1 pd == 3'h0) else $error("pull-down kept on reset");
  wd_default_a: assert property (
    wd_expire |=> ##1 die_thermal_reg_threshold == 2'h3 && adjust_cfg == 8'h7a
      && window_cfg == 8'h54) else $error("watchdog defaults wrong");
  ovr_status_a: assert property (
    window_cfg.thermistor_override && $past(window_cfg.thermistor_override)
      |-> th_status == '0) else $error("status not masked");
  ovr_good_a: assert property (
    window_cfg.thermistor_override && $past(window_cfg.thermistor_override)
      |-> th_good) else $error("good not forced");
  rsvd_read_a: assert property (
    reg_rvalid && $past(reg_addr) != 8'h18 |-> !reg_rdata[0]) else $error("reserved bit set");
  hot_off_a: assert property (
    window_dec.hot_limit_off == (window_cfg.reverse_supply_hot_limit == 2'h3))
    else $error("hot limit off wrong");
  cover property (wd_expire);
  cover property (reg_reset);
  cover property (window_cfg.thermistor_override && th_good);
endmodule : tncr_top_chk
bind tncr_top tncr_top_chk #(.TH_BITS(TH_BITS)) chk_u (
  .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .wd_expire(wd_expire), .reg_reset(reg_reset),
  .th_status(th_status), .th_good(th_good), .die_reg_degc(die_reg_degc),
  .die_thermal_reg_threshold(die_thermal_reg_threshold),
  .input_rail_pulldown_enable(input_rail_pulldown_enable),
  .sense_node_a_pulldown_enable(sense_node_a_pulldown_enable),
  .sense_node_b_pulldown_enable(sense_node_b_pulldown_enable),
  .adjust_cfg(adjust_cfg), .window_cfg(window_cfg), .window_dec(window_dec));
`default_nettype wire
